// >>> hdl/prog_port_pkg.sv
// Purpose: Shared constants and types for the programming port select
//          and output stop control block.
// Assumes: Configuration word is presented as a flat 96-bit vector.
// Notes:   Slave address top bits are arbitrary, not a maker code.

package prog_port_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int NUM_BANKS = 5;
  localparam int CFG_W     = 96;
  localparam int IR_W      = 4;

  // ------------------------------------------------------------------
  // Configuration bit positions
  // ------------------------------------------------------------------
  localparam int CFG_CTRL_25V     = 61;
  localparam int CFG_STOP_GATED   = 59;
  localparam int CFG_STOP_LEVEL   = 58;
  localparam int CFG_BANK_DIS_TOP = 56;  // Bank 1; later banks count down

  // ------------------------------------------------------------------
  // Reset values and counts
  // ------------------------------------------------------------------
  localparam logic [1:0]      STRAP_WAIT = 2'h3;
  localparam logic [IR_W-1:0] IR_RESET   = 4'hF;  // Bypass
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_BYPASS  = 4'hF;
  localparam logic [2:0]      I2C_ADDR_TOP = 3'h5;  // Arbitrary value

  // Three-level strap codes
  localparam logic [1:0] STRAP_LOW   = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_HIGH  = 2'h2;

  // ------------------------------------------------------------------
  // Test access port states
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET   = 4'h0,
    TAP_IDLE    = 4'h1,
    TAP_SEL_DR  = 4'h2,
    TAP_CAP_DR  = 4'h3,
    TAP_SH_DR   = 4'h4,
    TAP_EX1_DR  = 4'h5,
    TAP_PAU_DR  = 4'h6,
    TAP_EX2_DR  = 4'h7,
    TAP_UPD_DR  = 4'h8,
    TAP_SEL_IR  = 4'h9,
    TAP_CAP_IR  = 4'hA,
    TAP_SH_IR   = 4'hB,
    TAP_EX1_IR  = 4'hC,
    TAP_PAU_IR  = 4'hD,
    TAP_EX2_IR  = 4'hE,
    TAP_UPD_IR  = 4'hF
  } tap_state_t;

endpackage

// >>> hdl/sync2.sv
// Purpose: Two-flop synchroniser, one lane per bit.
// Assumes: Each bit is an independent level.
// Notes:   First stage feeds only the second stage.

`timescale 1ns/1ns

module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // ------------------------------------------------------------------
  // Per-bit stages
  // ------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      // Two stages to let metastability settle
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else
        begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate

endmodule

// >>> hdl/prog_port_select.sv
// Purpose: Shared programming pin routing (JTAG or I2C), the test access
//          controller, and the stop behaviour of disabled clock outputs.
// Assumes: test_clock is shared pin C; straps are static boards ties.
// Notes:   Output clock paths are muxed, not registered, to keep edges.
//
// Behaviour
// - Stop pin high or cfg bit 59 set gates disabled outputs to bit 58 level.
// - Level 0 holds true outputs high, complements low; level 1 inverts that.
// - Stop pin low and bit 59 clear tri-states disabled outputs.
// - Stop style applies to bank disable and to power-down.
// - Low on reset/select pin asynchronously resets test access logic.
// - Select pin high routes the four shared pins to JTAG.
// - Select pin low routes pins to I2C and forces test-logic-reset.
// - Pins pair: TDO/strap hi, TMS/strap lo, TCK/SCL, TDI/SDA.
// - Test data out is high impedance unless shifting.
// - Test data out changes on falling test clock edge.
// - Mode select sampled on rising test clock edge; host sets it earlier.
// - Test data in captured on rising test clock edge.
// - I2C slave address formed from the two strap pins.
// - Cfg bit 61 selects 1.8V or 2.5V control input levels.
// - Bank disabled when its pin is high or its cfg bit is one.
// - Power-down low disables clock inputs; outputs take stop state.

`timescale 1ns/1ns

module prog_port_select #(
  parameter int NB = prog_port_pkg::NUM_BANKS,
  parameter int IW = prog_port_pkg::IR_W
) (
  // Clocks and reset
  input  wire logic                              mclk,
  input  wire logic                              rst,
  input  wire logic                              test_clock,
  // Shared programming pins
  input  wire logic                              prog_sel_trst_n,
  input  wire logic                              pin_a_in,
  input  wire logic                              pin_a_float,
  output logic                                   pin_a_out,
  output logic                                   pin_a_oe,
  input  wire logic                              pin_b_in,
  input  wire logic                              pin_b_float,
  input  wire logic                              pin_d_in,
  output logic                                   pin_d_out,
  output logic                                   pin_d_oe,
  // JTAG data register side, test_clock domain
  output logic [IW-1:0]                          jtag_ir_q,
  output logic                                   jtag_tdi_q,
  output logic                                   jtag_capture_dr,
  output logic                                   jtag_shift_dr,
  output logic                                   jtag_update_dr,
  input  wire logic                              jtag_dr_serial_out,
  // I2C core side
  output logic                                   i2c_scl,
  output logic                                   i2c_sda_in,
  input  wire logic                              i2c_sda_drive_low,
  output logic                                   i2c_active,
  output logic [6:0]                             i2c_slave_addr,
  // Output stop controls
  input  wire logic                              output_stop_style_pin,
  input  wire logic [NB-1:0]                     bank_sync_disable_pin,
  input  wire logic                              power_down_n,
  input  wire logic [prog_port_pkg::CFG_W-1:0]   cfg_bits,
  output logic                                   clock_inputs_enable,
  output logic                                   ctrl_level_25v,
  // Clock output stage
  input  wire logic [NB-1:0]                     bank_clk_src,
  input  wire logic                              fb_clk_src,
  output logic [NB-1:0]                          bank_clock_out,
  output logic [NB-1:0]                          bank_clock_out_n,
  output logic [NB-1:0]                          bank_clock_oe,
  output logic                                   feedback_clock_out,
  output logic                                   feedback_clock_out_n,
  output logic                                   feedback_clock_oe
);

  // ------------------------------------------------------------------
  // Pin synchronisers into mclk
  // ------------------------------------------------------------------
  localparam int SW = NB + 7;
  logic [SW-1:0] sync_in;
  logic [SW-1:0] sync_out;
  logic [NB-1:0] s_dis;
  logic          s_stop_pin;
  logic          s_pd_n;
  logic          s_sel;
  logic          s_a_in;
  logic          s_a_fl;
  logic          s_b_in;
  logic          s_b_fl;

  // Every pin level here crosses two flops before use in the mclk domain
  assign sync_in = {bank_sync_disable_pin, output_stop_style_pin, power_down_n,
                    prog_sel_trst_n, pin_a_in, pin_a_float, pin_b_in, pin_b_float};

  sync2 #(
    .WIDTH (SW)
  ) u_sync (
    .clk (mclk),
    .rst (rst),
    .d   (sync_in),
    .q   (sync_out)
  );

  assign {s_dis, s_stop_pin, s_pd_n, s_sel, s_a_in, s_a_fl, s_b_in, s_b_fl} = sync_out;

  // ------------------------------------------------------------------
  // Output stop control, mclk domain
  // ------------------------------------------------------------------
  logic [NB-1:0] bank_en_q;
  logic [NB-1:0] bank_en_d;
  logic          fb_en_q;
  logic          fb_en_d;
  logic          gated_q;
  logic          gated_d;
  logic          level_q;
  logic          level_d;
  logic          pdn_q;
  logic          pdn_d;
  logic          lvl25_q;
  logic          lvl25_d;
  logic          i2c_act_q;
  logic          i2c_act_d;
  logic [NB-1:0] cfg_dis;

  // Bank 1 sits at the top disable bit, later banks below it
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++)
    begin : g_cfgdis
      assign cfg_dis[gi] = cfg_bits[prog_port_pkg::CFG_BANK_DIS_TOP - gi];
    end
  endgenerate

  // Next control state; registering it makes the disable synchronous
  always_comb
  begin
    bank_en_d = ~(s_dis | cfg_dis) & {NB{s_pd_n}};
    fb_en_d   = s_pd_n;
    gated_d   = s_stop_pin | cfg_bits[prog_port_pkg::CFG_STOP_GATED];
    level_d   = cfg_bits[prog_port_pkg::CFG_STOP_LEVEL];
    pdn_d     = s_pd_n;
    lvl25_d   = cfg_bits[prog_port_pkg::CFG_CTRL_25V];
    i2c_act_d = ~s_sel;
  end

  // Control registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bank_en_q <= '0;
      fb_en_q   <= 1'b0;
      gated_q   <= 1'b0;
      level_q   <= 1'b0;
      pdn_q     <= 1'b0;
      lvl25_q   <= 1'b0;
      i2c_act_q <= 1'b0;
    end
    else
    begin
      bank_en_q <= bank_en_d;
      fb_en_q   <= fb_en_d;
      gated_q   <= gated_d;
      level_q   <= level_d;
      pdn_q     <= pdn_d;
      lvl25_q   <= lvl25_d;
      i2c_act_q <= i2c_act_d;
    end
  end

  assign clock_inputs_enable = pdn_q;
  assign ctrl_level_25v      = lvl25_q;
  assign i2c_active          = i2c_act_q;

  // Output stage: enabled passes the clock, else stop level or float
  always_comb
  begin
    for (int b = 0; b < NB; b++)
    begin
      bank_clock_out[b]   = bank_en_q[b] ? bank_clk_src[b] : ~level_q;
      bank_clock_out_n[b] = bank_en_q[b] ? ~bank_clk_src[b] : level_q;
      bank_clock_oe[b]    = bank_en_q[b] | gated_q;
    end
    feedback_clock_out   = fb_en_q ? fb_clk_src : ~level_q;
    feedback_clock_out_n = fb_en_q ? ~fb_clk_src : level_q;
    feedback_clock_oe    = fb_en_q | gated_q;
  end

  // ------------------------------------------------------------------
  // Strap capture for the I2C address
  // ------------------------------------------------------------------
  logic [1:0] wait_q;
  logic [1:0] wait_d;
  logic       done_q;
  logic       done_d;
  logic [6:0] addr_q;
  logic [6:0] addr_d;
  logic [1:0] hi_code;
  logic [1:0] lo_code;

  // Straps are static, so one sample after the synchroniser fills suffices
  always_comb
  begin
    hi_code = s_a_fl ? prog_port_pkg::STRAP_FLOAT :
              (s_a_in ? prog_port_pkg::STRAP_HIGH : prog_port_pkg::STRAP_LOW);
    lo_code = s_b_fl ? prog_port_pkg::STRAP_FLOAT :
              (s_b_in ? prog_port_pkg::STRAP_HIGH : prog_port_pkg::STRAP_LOW);
    wait_d  = wait_q;
    done_d  = done_q;
    addr_d  = addr_q;
    if (wait_q != prog_port_pkg::STRAP_WAIT)
    begin
      wait_d = wait_q + 2'h1;
    end
    else if (!done_q)
    begin
      done_d = 1'b1;
      addr_d = {prog_port_pkg::I2C_ADDR_TOP,
                {1'b0, hi_code, 1'b0} + {2'h0, hi_code} + {2'h0, lo_code}};
    end
  end

  // Strap registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wait_q <= 2'h0;
      done_q <= 1'b0;
      addr_q <= 7'h00;
    end
    else
    begin
      wait_q <= wait_d;
      done_q <= done_d;
      addr_q <= addr_d;
    end
  end

  assign i2c_slave_addr = addr_q;

  // ------------------------------------------------------------------
  // Test access controller, test_clock domain
  // ------------------------------------------------------------------
  prog_port_pkg::tap_state_t tap_q;
  prog_port_pkg::tap_state_t tap_d;
  logic [IW-1:0] ir_sh_q;
  logic [IW-1:0] ir_sh_d;
  logic [IW-1:0] ir_q;
  logic [IW-1:0] ir_d;
  logic          byp_q;
  logic          byp_d;
  logic          tdi_q;
  logic          tdi_d;
  logic          tdo_q;
  logic          tdo_d;
  logic          tdo_oe_q;
  logic          tdo_oe_d;
  logic          shifting;

  // Next state from mode select (pin B) on each rising edge
  always_comb
  begin
    tap_d = tap_q;
    case (tap_q)
      prog_port_pkg::TAP_RESET:  tap_d = pin_b_in ? prog_port_pkg::TAP_RESET
                                                  : prog_port_pkg::TAP_IDLE;
      prog_port_pkg::TAP_IDLE:   tap_d = pin_b_in ? prog_port_pkg::TAP_SEL_DR
                                                  : prog_port_pkg::TAP_IDLE;
      prog_port_pkg::TAP_SEL_DR: tap_d = pin_b_in ? prog_port_pkg::TAP_SEL_IR
                                                  : prog_port_pkg::TAP_CAP_DR;
      prog_port_pkg::TAP_CAP_DR: tap_d = pin_b_in ? prog_port_pkg::TAP_EX1_DR
                                                  : prog_port_pkg::TAP_SH_DR;
      prog_port_pkg::TAP_SH_DR:  tap_d = pin_b_in ? prog_port_pkg::TAP_EX1_DR
                                                  : prog_port_pkg::TAP_SH_DR;
      prog_port_pkg::TAP_EX1_DR: tap_d = pin_b_in ? prog_port_pkg::TAP_UPD_DR
                                                  : prog_port_pkg::TAP_PAU_DR;
      prog_port_pkg::TAP_PAU_DR: tap_d = pin_b_in ? prog_port_pkg::TAP_EX2_DR
                                                  : prog_port_pkg::TAP_PAU_DR;
      prog_port_pkg::TAP_EX2_DR: tap_d = pin_b_in ? prog_port_pkg::TAP_UPD_DR
                                                  : prog_port_pkg::TAP_SH_DR;
      prog_port_pkg::TAP_UPD_DR: tap_d = pin_b_in ? prog_port_pkg::TAP_SEL_DR
                                                  : prog_port_pkg::TAP_IDLE;
      prog_port_pkg::TAP_SEL_IR: tap_d = pin_b_in ? prog_port_pkg::TAP_RESET
                                                  : prog_port_pkg::TAP_CAP_IR;
      prog_port_pkg::TAP_CAP_IR: tap_d = pin_b_in ? prog_port_pkg::TAP_EX1_IR
                                                  : prog_port_pkg::TAP_SH_IR;
      prog_port_pkg::TAP_SH_IR:  tap_d = pin_b_in ? prog_port_pkg::TAP_EX1_IR
                                                  : prog_port_pkg::TAP_SH_IR;
      prog_port_pkg::TAP_EX1_IR: tap_d = pin_b_in ? prog_port_pkg::TAP_UPD_IR
                                                  : prog_port_pkg::TAP_PAU_IR;
      prog_port_pkg::TAP_PAU_IR: tap_d = pin_b_in ? prog_port_pkg::TAP_EX2_IR
                                                  : prog_port_pkg::TAP_PAU_IR;
      prog_port_pkg::TAP_EX2_IR: tap_d = pin_b_in ? prog_port_pkg::TAP_UPD_IR
                                                  : prog_port_pkg::TAP_SH_IR;
      prog_port_pkg::TAP_UPD_IR: tap_d = pin_b_in ? prog_port_pkg::TAP_SEL_DR
                                                  : prog_port_pkg::TAP_IDLE;
      default:                   tap_d = prog_port_pkg::TAP_RESET;
    endcase
  end

  // Instruction and bypass shifting; test data in is pin D
  always_comb
  begin
    ir_sh_d = ir_sh_q;
    ir_d    = ir_q;
    byp_d   = byp_q;
    tdi_d   = pin_d_in;
    case (tap_q)
      prog_port_pkg::TAP_RESET:  ir_d    = prog_port_pkg::IR_RESET;
      prog_port_pkg::TAP_CAP_IR: ir_sh_d = prog_port_pkg::IR_CAPTURE;
      prog_port_pkg::TAP_SH_IR:  ir_sh_d = {pin_d_in, ir_sh_q[IW-1:1]};
      prog_port_pkg::TAP_UPD_IR: ir_d    = ir_sh_q;
      prog_port_pkg::TAP_CAP_DR: byp_d   = 1'b0;
      prog_port_pkg::TAP_SH_DR:  byp_d   = pin_d_in;
      default:                   byp_d   = byp_q;
    endcase
  end

  // Rising-edge registers; select low holds the controller in reset
  always_ff @(posedge test_clock or negedge prog_sel_trst_n)
  begin
    if (!prog_sel_trst_n)
    begin
      tap_q   <= prog_port_pkg::TAP_RESET;
      ir_sh_q <= prog_port_pkg::IR_RESET;
      ir_q    <= prog_port_pkg::IR_RESET;
      byp_q   <= 1'b0;
      tdi_q   <= 1'b0;
    end
    else
    begin
      tap_q   <= tap_d;
      ir_sh_q <= ir_sh_d;
      ir_q    <= ir_d;
      byp_q   <= byp_d;
      tdi_q   <= tdi_d;
    end
  end

  // Output data is chosen from the state held since the last rising edge
  always_comb
  begin
    shifting = (tap_q == prog_port_pkg::TAP_SH_IR) || (tap_q == prog_port_pkg::TAP_SH_DR);
    tdo_oe_d = shifting;
    if (tap_q == prog_port_pkg::TAP_SH_IR)
      tdo_d = ir_sh_q[0];
    else if (ir_q == prog_port_pkg::IR_BYPASS)
      tdo_d = byp_q;
    else
      tdo_d = jtag_dr_serial_out;
  end

  // Falling edge keeps a half period of hold for the far side
  always_ff @(negedge test_clock or negedge prog_sel_trst_n)
  begin
    if (!prog_sel_trst_n)
    begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end
    else
    begin
      tdo_q    <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
    end
  end

  assign jtag_ir_q       = ir_q;
  assign jtag_tdi_q      = tdi_q;
  assign jtag_capture_dr = (tap_q == prog_port_pkg::TAP_CAP_DR);
  assign jtag_shift_dr   = (tap_q == prog_port_pkg::TAP_SH_DR);
  assign jtag_update_dr  = (tap_q == prog_port_pkg::TAP_UPD_DR);

  // ------------------------------------------------------------------
  // Shared pin routing; pure muxing, select is taken straight from the pin
  // ------------------------------------------------------------------
  assign pin_a_out  = tdo_q;
  assign pin_a_oe   = prog_sel_trst_n & tdo_oe_q;
  assign pin_d_out  = 1'b0;
  assign pin_d_oe   = ~prog_sel_trst_n & i2c_sda_drive_low;
  assign i2c_scl    = prog_sel_trst_n | test_clock;
  assign i2c_sda_in = prog_sel_trst_n | pin_d_in;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_bank0_stopped;
    !bank_en_q[0] && gated_q;
  endsequence

  property p_gated_level;
    @(posedge mclk) disable iff (rst)
    s_bank0_stopped |-> bank_clock_out[0] == ~level_q && bank_clock_out_n[0] == level_q
                        && bank_clock_oe[0];
  endproperty
  a_gated_level: assert property (p_gated_level) else $error("stop level wrong");

  property p_tristate;
    @(posedge mclk) disable iff (rst)
    (!bank_en_q[0] && !gated_q) |-> !bank_clock_oe[0];
  endproperty
  a_tristate: assert property (p_tristate) else $error("disabled bank driven");

  property p_gated_src;
    @(posedge mclk) disable iff (rst)
    (s_stop_pin || cfg_bits[prog_port_pkg::CFG_STOP_GATED]) |=> gated_q;
  endproperty
  a_gated_src: assert property (p_gated_src) else $error("gating not taken");

  property p_bank_dis;
    @(posedge mclk) disable iff (rst)
    (s_dis[0] || cfg_dis[0]) |=> !bank_en_q[0] ##0 !bank_clock_oe[0] || gated_q;
  endproperty
  a_bank_dis: assert property (p_bank_dis) else $error("bank not disabled");

  sequence s_pd_low;
    !s_pd_n ##1 !s_pd_n;
  endsequence

  property p_pd_stop;
    @(posedge mclk) disable iff (rst)
    s_pd_low |-> !fb_en_q && !clock_inputs_enable && bank_en_q == '0;
  endproperty
  a_pd_stop: assert property (p_pd_stop) else $error("power-down not applied");

  property p_route;
    @(posedge mclk) disable iff (rst)
    !prog_sel_trst_n |-> !pin_a_oe && i2c_scl == test_clock;
  endproperty
  a_route: assert property (p_route) else $error("pins not routed to I2C");

  property p_tap_reset;
    @(posedge test_clock) disable iff (!prog_sel_trst_n)
    pin_b_in [*5] |=> tap_q == prog_port_pkg::TAP_RESET;
  endproperty
  a_tap_reset: assert property (p_tap_reset) else $error("no reset after 5 ones");

  property p_idle;
    @(posedge test_clock) disable iff (!prog_sel_trst_n)
    (tap_q == prog_port_pkg::TAP_RESET && !pin_b_in) |=> tap_q == prog_port_pkg::TAP_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("mode select ignored");

  property p_tdi;
    @(posedge test_clock) disable iff (!prog_sel_trst_n)
    tap_q == prog_port_pkg::TAP_SH_IR |=> ir_sh_q[IW-1] == $past(pin_d_in);
  endproperty
  a_tdi: assert property (p_tdi) else $error("test data in lost");

  property p_tdo_oe;
    @(posedge test_clock) disable iff (!prog_sel_trst_n)
    tdo_oe_q == shifting;
  endproperty
  a_tdo_oe: assert property (p_tdo_oe) else $error("test data out enable wrong");

endmodule

// >>> bench/jtag_host.sv
// Purpose: JTAG programming host model on the shared test pins.
// Assumes: Test clock period 12 ns, idle low between frames.
// Notes:   Bench calls step once per test clock cycle.
`timescale 1ns/1ns
module jtag_host (
  // Test pins
  output logic tck,
  output logic tms,
  output logic tdi
);
  // Idle with mode select high so the controller parks in reset
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Pins settle half a period before the rising edge
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #6 tck = 1'b1;
    #6 tck = 1'b0;
  endtask
endmodule

// >>> bench/prog_port_select_tb.sv
// Purpose: Self-checking bench for port select and output stop.
// Assumes: Straps are static through reset; sampled once after it.
// Notes:   Pin inputs need three mclk edges to reach the outputs.
`timescale 1ns/1ns
module prog_port_select_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk, tck, tms, tdi, a_out, a_oe, d_oe, scl, sda_in, act, cie, lv25;
  logic rst = 1'b1, sel_n = 1'b0, sda_low = 1'b1, stop_pin = 1'b0, pd_n = 1'b1;
  logic [4:0] dis_pin = 5'h00, src = 5'h00, q, q_n, q_oe;
  logic [prog_port_pkg::CFG_W-1:0] cfg = '0;
  logic [3:0] ir;
  logic [6:0] addr;
  logic fb, fb_n, fb_oe;
  int n_fail = 0, check_count = 0;
  jtag_host jtag_host_inst (.tck(tck), .tms(tms), .tdi(tdi));
  // Strap hi stays tied floating all run; strap lo follows tms, high until the JTAG steps
  prog_port_select prog_port_select_inst (.mclk(mclk), .rst(rst), .test_clock(tck),
    .prog_sel_trst_n(sel_n), .pin_a_in(1'b0), .pin_a_float(1'b1), .pin_a_out(a_out),
    .pin_a_oe(a_oe), .pin_b_in(tms), .pin_b_float(1'b0), .pin_d_in(tdi), .pin_d_out(),
    .pin_d_oe(d_oe), .jtag_ir_q(ir), .jtag_tdi_q(), .jtag_capture_dr(), .jtag_shift_dr(),
    .jtag_update_dr(), .jtag_dr_serial_out(1'b0), .i2c_scl(scl), .i2c_sda_in(sda_in),
    .i2c_sda_drive_low(sda_low), .i2c_active(act), .i2c_slave_addr(addr),
    .output_stop_style_pin(stop_pin), .bank_sync_disable_pin(dis_pin), .power_down_n(pd_n),
    .cfg_bits(cfg), .clock_inputs_enable(cie), .ctrl_level_25v(lv25), .bank_clk_src(src),
    .fb_clk_src(1'b0), .bank_clock_out(q), .bank_clock_out_n(q_n), .bank_clock_oe(q_oe),
    .feedback_clock_out(fb), .feedback_clock_out_n(fb_n), .feedback_clock_oe(fb_oe));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_i2c();
    chk({1'b0, addr}, 8'h55);
    chk({act, scl, sda_in, d_oe, a_oe}, 8'h12);
  endtask
  task automatic t_stop();
    // Enabled banks must pass their source straight through
    src = 5'h0A;
    w(1);
    chk(q, 8'h0A);
    chk(q_n, 8'h15);
    src = 5'h00;
    cfg[59] = 1'b1;
    cfg[56] = 1'b1;
    w(2);
    chk({q[0], q_n[0], q_oe[0]}, 8'h05);
    cfg[58] = 1'b1;
    w(2);
    chk({q[0], q_n[0], q_oe[0]}, 8'h03);
    cfg[59] = 1'b0;
    dis_pin[4] = 1'b1;
    w(4);
    chk(q_oe, 8'h0E);
    stop_pin = 1'b1;
    w(4);
    chk(q_oe, 8'h1F);
    stop_pin = 1'b0;
    cfg[56] = 1'b0;
    dis_pin = 5'h00;
  endtask
  task automatic t_pd();
    cfg[59] = 1'b1;
    cfg[58] = 1'b0;
    cfg[61] = 1'b1;
    pd_n = 1'b0;
    w(4);
    chk({cie, fb, fb_n, fb_oe, lv25}, 8'h0B);
    chk(q, 8'h1F);
    chk(q_oe, 8'h1F);
    pd_n = 1'b1;
  endtask
  task automatic t_jtag();
    sel_n = 1'b1;
    w(1);
    chk({scl, sda_in, d_oe}, 8'h06);
    jtag_host_inst.step(0, 0);
    jtag_host_inst.step(1, 0);
    jtag_host_inst.step(1, 0);
    jtag_host_inst.step(0, 0);
    jtag_host_inst.step(0, 0);
    #1 chk({a_oe, a_out}, 8'h03);
    jtag_host_inst.step(0, 0);
    jtag_host_inst.step(0, 1);
    jtag_host_inst.step(0, 0);
    jtag_host_inst.step(1, 1);
    #1 chk(a_oe, 8'h00);
    jtag_host_inst.step(1, 0);
    jtag_host_inst.step(0, 0);
    chk(ir, 8'h0A);
    w(1);
    sel_n = 1'b0;
    #1 chk(ir, 8'h0F);
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    #100000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    w(6);
    rst = 1'b0;
    w(6);
    t_i2c();
    t_stop();
    t_pd();
    t_jtag();
    end_of_test();
  end
endmodule
